// ==== design/link_cap_pkg.sv ====
// Package: offsets, field layout and reset values of the link capabilities register
package link_cap_pkg;
    localparam logic [11:0] LINK_CAP_OFFSET = 12'h04c;
    localparam logic [11:0] SW_CTRL_OFFSET = 12'h100;
    localparam logic [11:0] LINK_CTRL_OFFSET = 12'h050;
    // Field positions
    localparam int SPEED_LSB = 0;
    localparam int SPEED_MSB = 3;
    localparam int WIDTH_LSB = 4;
    localparam int WIDTH_MSB = 9;
    localparam int PSS_LSB = 10;
    localparam int PSS_MSB = 11;
    localparam int SHALLOW_LSB = 12;
    localparam int SHALLOW_MSB = 14;
    localparam int DEEP_LSB = 15;
    localparam int DEEP_MSB = 17;
    localparam int REFCLK_BIT = 18;
    localparam int SDOWN_BIT = 19;
    localparam int LACT_BIT = 20;
    localparam int PORT_LSB = 24;
    localparam int PORT_MSB = 31;
    localparam int COMMON_REFCLK_CONFIG_BIT = 6;
    localparam int UNLOCK_BIT = 0;
    // Reset and fixed values
    localparam logic [3:0] SPEED_RESET = 4'h1;
    localparam logic [1:0] PSS_FIXED = 2'h3;
    localparam logic [2:0] SHALLOW_SEPARATE = 3'h5;
    localparam logic [2:0] SHALLOW_COMMON = 3'h3;
    localparam logic [2:0] DEEP_RESET = 3'h2;
    localparam logic REFCLK_RESET = 1'h0;
    localparam logic [5:0] WIDTH_X1 = 6'h01;
    localparam logic [5:0] WIDTH_X2 = 6'h02;
endpackage : link_cap_pkg

// ==== design/switch_port_link_capabilities.sv ====
// Link capabilities register bank of one switch port, APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps

// Function
// - Speed field reads fixed code 1
// - Width field resets to port lane width
// - Upstream port may overwrite width narrower
// - Reserved width code runs link single-lane
// - Power-state support fixed at 3, unwritable
// - Separate clocks: shallow latency reads 5
// - Common clock: shallow latency reads 3
// - Clock choice follows common clock bit
// - Deep exit latency resets to 2
// - Refclk removal bit resets to 0
// - Surprise-down bit: downstream 1, upstream 0
// - Link-active bit: downstream 1, upstream 0
// - Port number field returns port index
module switch_port_link_capabilities #(
    parameter logic [7:0] PORT_INDEX = 8'h00,
    parameter bit IS_UPSTREAM = 1'b1,
    parameter logic [5:0] LANE_WIDTH = 6'h02
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link control neighbour
    input wire logic commonRefclkConfig,
    // To the link logic
    output logic [5:0] trainWidth
);
    import link_cap_pkg::*;

    // ************************************************************
    // Register state
    // ************************************************************
    logic [5:0] maxWidth_reg;
    logic [2:0] deepLat_reg;
    logic refclkCap_reg;
    logic sdownCap_reg;
    logic lactCap_reg;
    logic unlock_reg;
    logic [2:0] shallowLat;
    logic [31:0] capWord;
    logic wrStrobe;
    logic capWrite;

    function automatic logic widthValid(input logic [5:0] w);
        return (w == WIDTH_X1) || (w == WIDTH_X2);
    endfunction : widthValid

    assign wrStrobe = psel && penable && pwrite;
    assign pready = 1'b1;
    assign capWrite = wrStrobe && paddr == LINK_CAP_OFFSET;

    // Only the upstream end may narrow; downstream keeps its native width
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            maxWidth_reg <= LANE_WIDTH;
        end else if (wrStrobe && paddr == LINK_CAP_OFFSET && unlock_reg && IS_UPSTREAM) begin
            maxWidth_reg <= pwdata[WIDTH_MSB:WIDTH_LSB];
        end
    end

    // Deep exit latency, lockable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            deepLat_reg <= DEEP_RESET;
        end else if (capWrite && unlock_reg) begin
            deepLat_reg <= pwdata[DEEP_MSB:DEEP_LSB];
        end
    end

    // Reference clock removal capability, lockable
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            refclkCap_reg <= REFCLK_RESET;
        end else if (capWrite && unlock_reg) begin
            refclkCap_reg <= pwdata[REFCLK_BIT];
        end
    end

    // Upstream must keep this at zero whatever software writes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdownCap_reg <= !IS_UPSTREAM;
        end else if (capWrite && unlock_reg) begin
            sdownCap_reg <= pwdata[SDOWN_BIT] && !IS_UPSTREAM;
        end
    end

    // Upstream must keep this at zero whatever software writes
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lactCap_reg <= !IS_UPSTREAM;
        end else if (capWrite && unlock_reg) begin
            lactCap_reg <= pwdata[LACT_BIT] && !IS_UPSTREAM;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            unlock_reg <= 1'b0;
        end else if (wrStrobe && paddr == SW_CTRL_OFFSET) begin
            unlock_reg <= pwdata[UNLOCK_BIT];
        end
    end

    // ************************************************************
    // Read side
    // ************************************************************
    assign shallowLat = commonRefclkConfig ? SHALLOW_COMMON : SHALLOW_SEPARATE;

    // Registered so the link sees a clean width; it lags a write by one cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            trainWidth <= widthValid(LANE_WIDTH) ? LANE_WIDTH : WIDTH_X1;
        end else begin
            trainWidth <= widthValid(maxWidth_reg) ? maxWidth_reg : WIDTH_X1;
        end
    end

    always_comb begin
        capWord = 32'h0;
        capWord[SPEED_MSB:SPEED_LSB] = SPEED_RESET;
        capWord[WIDTH_MSB:WIDTH_LSB] = maxWidth_reg;
        capWord[PSS_MSB:PSS_LSB] = PSS_FIXED;
        capWord[SHALLOW_MSB:SHALLOW_LSB] = shallowLat;
        capWord[DEEP_MSB:DEEP_LSB] = deepLat_reg;
        capWord[REFCLK_BIT] = refclkCap_reg;
        capWord[SDOWN_BIT] = sdownCap_reg;
        capWord[LACT_BIT] = lactCap_reg;
        capWord[PORT_MSB:PORT_LSB] = PORT_INDEX;
    end

    // Read data registered at setup so it is stable in the access phase
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            unique case (paddr)
                LINK_CAP_OFFSET: prdata <= capWord;
                SW_CTRL_OFFSET: prdata <= {31'h0, unlock_reg};
                default: begin
                    prdata <= 32'h0;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    sequence lockedCapWrite;
        wrStrobe && paddr == LINK_CAP_OFFSET && !unlock_reg;
    endsequence

    AST_SPEED: assert property (@(posedge clk) disable iff (!rst_b)
        capWord[SPEED_MSB:SPEED_LSB] == 4'h1) else $error("speed field wrong");
    AST_WIDTH_RESET: assert property (@(posedge clk) $rose(rst_b) |->
        maxWidth_reg == LANE_WIDTH) else $error("width not at lane width");
    AST_WIDTH_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
        lockedCapWrite |=> $stable(maxWidth_reg) && $stable(deepLat_reg))
        else $error("locked write changed field");
    AST_WIDTH_X1: assert property (@(posedge clk) disable iff (!rst_b)
        !widthValid(maxWidth_reg) |=> trainWidth == 6'h01) else $error("bad width not x1");
    AST_PSS: assert property (@(posedge clk) disable iff (!rst_b)
        capWord[PSS_MSB:PSS_LSB] == 2'h3) else $error("power state support wrong");
    AST_SHALLOW: assert property (@(posedge clk) disable iff (!rst_b)
        capWord[SHALLOW_MSB:SHALLOW_LSB] == (commonRefclkConfig ? 3'h3 : 3'h5))
        else $error("shallow latency wrong");
    AST_UPSTREAM_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        IS_UPSTREAM |-> !sdownCap_reg && !lactCap_reg) else $error("upstream bits set");
    AST_PORT: assert property (@(posedge clk) disable iff (!rst_b)
        capWord[PORT_MSB:PORT_LSB] == PORT_INDEX && capWord[23:21] == 3'h0)
        else $error("port or reserved wrong");
    AST_DEEP_RESET: assert property (@(posedge clk) $rose(rst_b) |->
        deepLat_reg == 3'h2 && !refclkCap_reg) else $error("deep latency reset wrong");

    // ************************************************************
    // Bus and field checks
    // ************************************************************
    // Setup cycle of an access to the capabilities word
    sequence capSetup;
        psel && !penable && paddr == LINK_CAP_OFFSET;
    endsequence

    // Setup cycle of an access to the unlock word
    sequence ctrlSetup;
        psel && !penable && paddr == SW_CTRL_OFFSET;
    endsequence

    // Setup cycle of an access to no decoded word
    sequence straySetup;
        psel && !penable && paddr != LINK_CAP_OFFSET && paddr != SW_CTRL_OFFSET;
    endsequence

    // Capabilities write while software holds the unlock
    sequence openCapWrite;
        capWrite && unlock_reg;
    endsequence

    // Write to the unlock word
    sequence unlockWrite;
        wrStrobe && paddr == SW_CTRL_OFFSET;
    endsequence

    // Write to an address nothing decodes
    sequence strayWrite;
        wrStrobe && paddr != LINK_CAP_OFFSET && paddr != SW_CTRL_OFFSET;
    endsequence

    // First edge out of reset
    sequence resetRelease;
        $rose(rst_b);
    endsequence

    // A read of the capabilities word returns the assembled word
    AST_CAP_READ: assert property (@(posedge clk) disable iff (!rst_b)
        capSetup |=> prdata == $past(capWord) && !pslverr)
        else $error("capabilities read wrong");

    // The unlock word reads back its bit
    AST_UNLOCK_READ: assert property (@(posedge clk) disable iff (!rst_b)
        ctrlSetup |=> prdata == {31'h0, $past(unlock_reg)} && !pslverr)
        else $error("unlock read wrong");

    // Unmapped reads answer zero with an error
    AST_ERR_READ: assert property (@(posedge clk) disable iff (!rst_b)
        straySetup |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not flagged");

    // Never a wait state
    AST_PREADY: assert property (@(posedge clk) disable iff (!rst_b)
        pready) else $error("pready low");

    // The unlock bit follows its write
    AST_UNLOCK_SET: assert property (@(posedge clk) disable iff (!rst_b)
        unlockWrite |=> unlock_reg == $past(pwdata[UNLOCK_BIT]))
        else $error("unlock write lost");

    // Upstream width takes the written code
    AST_WIDTH_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> !IS_UPSTREAM || maxWidth_reg == $past(pwdata[WIDTH_MSB:WIDTH_LSB]))
        else $error("width write lost");

    // Downstream width never moves off the lane width
    AST_WIDTH_DOWN: assert property (@(posedge clk) disable iff (!rst_b)
        !IS_UPSTREAM |-> maxWidth_reg == LANE_WIDTH)
        else $error("downstream width changed");

    // A legal width reaches the link unchanged
    AST_TRAIN_PASS: assert property (@(posedge clk) disable iff (!rst_b)
        widthValid(maxWidth_reg) |=> trainWidth == $past(maxWidth_reg))
        else $error("legal width not used");

    // The link never trains at a reserved width
    AST_TRAIN_LEGAL: assert property (@(posedge clk) disable iff (!rst_b)
        trainWidth == 6'h01 || trainWidth == 6'h02)
        else $error("train width reserved");

    // Unlocked deep latency write lands
    AST_DEEP_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> deepLat_reg == $past(pwdata[DEEP_MSB:DEEP_LSB]))
        else $error("deep latency write lost");

    // Unlocked clock removal write lands
    AST_REFCLK_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> refclkCap_reg == $past(pwdata[REFCLK_BIT]))
        else $error("refclk write lost");

    // Surprise-down write lands downstream only
    AST_SDOWN_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> sdownCap_reg == ($past(pwdata[SDOWN_BIT]) && !IS_UPSTREAM))
        else $error("surprise-down write wrong");

    // Link-active write lands downstream only
    AST_LACT_OPEN: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> lactCap_reg == ($past(pwdata[LACT_BIT]) && !IS_UPSTREAM))
        else $error("link-active write wrong");

    // Locked writes leave the single-bit fields alone
    AST_BITS_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
        lockedCapWrite |=> $stable(refclkCap_reg) && $stable(sdownCap_reg) && $stable(lactCap_reg))
        else $error("locked write changed bit");

    // Writes elsewhere leave width, deep latency and the unlock bit alone
    AST_STRAY_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        strayWrite |=> $stable(maxWidth_reg) && $stable(deepLat_reg) && $stable(unlock_reg))
        else $error("unmapped write changed state");

    // Separate clocks report the longer latency
    AST_SHALLOW_SEP: assert property (@(posedge clk) disable iff (!rst_b)
        !commonRefclkConfig |-> shallowLat == 3'h5)
        else $error("separate clock latency wrong");

    // Common clock reports the shorter latency
    AST_SHALLOW_COM: assert property (@(posedge clk) disable iff (!rst_b)
        commonRefclkConfig |-> shallowLat == 3'h3)
        else $error("common clock latency wrong");

    // Read-only fields survive an unlocked write of any value
    AST_SPEED_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> capWord[SPEED_MSB:SPEED_LSB] == 4'h1)
        else $error("speed field written");

    AST_PSS_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> capWord[PSS_MSB:PSS_LSB] == 2'h3)
        else $error("power state support written");

    AST_PORT_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> capWord[PORT_MSB:PORT_LSB] == PORT_INDEX)
        else $error("port number written");

    AST_RSVD_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> capWord[23:21] == 3'h0)
        else $error("reserved bits written");

    AST_SHALLOW_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
        openCapWrite |=> capWord[SHALLOW_MSB:SHALLOW_LSB] == (commonRefclkConfig ? 3'h3 : 3'h5))
        else $error("shallow latency written");

    // Port-side reset values
    AST_SDOWN_RESET: assert property (@(posedge clk)
        resetRelease |-> sdownCap_reg == !IS_UPSTREAM)
        else $error("surprise-down reset wrong");

    AST_LACT_RESET: assert property (@(posedge clk)
        resetRelease |-> lactCap_reg == !IS_UPSTREAM)
        else $error("link-active reset wrong");

    AST_REFCLK_RESET: assert property (@(posedge clk)
        resetRelease |-> !refclkCap_reg)
        else $error("refclk reset wrong");

    // Fields start locked so a stray boot write cannot change them
    AST_UNLOCK_RESET: assert property (@(posedge clk)
        resetRelease |-> !unlock_reg && !pslverr && prdata == 32'h0)
        else $error("unlock reset wrong");

    AST_TRAIN_RESET: assert property (@(posedge clk)
        resetRelease |-> trainWidth == (widthValid(LANE_WIDTH) ? LANE_WIDTH : 6'h01))
        else $error("train width reset wrong");
endmodule : switch_port_link_capabilities

// ==== test/test_switch_port_link_capabilities.sv ====
// Testbench for the link capabilities register bank
`timescale 1ns/100ps
module test_switch_port_link_capabilities;
    import link_cap_pkg::*;
    logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, commonRefclkConfig = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err;
    logic [5:0] trainWidth;
    logic [31:0] prdataDn, rdDn;
    logic pslverrDn;
    logic [5:0] trainWidthDn;
    int errors = 0, testsRun = 0, cycles = 0;
    // ****************************************
    // Upstream port 2 with two lanes
    // ****************************************
    switch_port_link_capabilities #(.PORT_INDEX(8'h02), .IS_UPSTREAM(1'b1),
        .LANE_WIDTH(6'h02)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .commonRefclkConfig(commonRefclkConfig), .trainWidth(trainWidth));
    // Downstream port 3 with one lane, on the same bus
    switch_port_link_capabilities #(.PORT_INDEX(8'h03), .IS_UPSTREAM(1'b0),
        .LANE_WIDTH(6'h01)) dn (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdataDn), .pready(),
        .pslverr(pslverrDn), .commonRefclkConfig(commonRefclkConfig),
        .trainWidth(trainWidthDn));
    initial begin
        forever #25 clk = ~clk;
    end
    // Guards against a slave that never answers
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Entered just after a rising edge; leaves one idle edge so strobes never clash
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        rdDn = prdataDn;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic reset_values();
        apb(1'b0, LINK_CAP_OFFSET, 32'h0);
        check(rd, 32'h02015c21);
        check({31'h0, err}, 32'h0);
        check({26'h0, trainWidth}, 32'h2);
        check(rdDn, 32'h03195c11);
        check({26'h0, trainWidthDn}, 32'h1);
    endtask : reset_values
    task automatic clock_choice();
        commonRefclkConfig <= 1'b1;
        apb(1'b0, LINK_CAP_OFFSET, 32'h0);
        check(rd, 32'h02013c21);
        commonRefclkConfig <= 1'b0;
        apb(1'b0, LINK_CAP_OFFSET, 32'h0);
        check(rd, 32'h02015c21);
    endtask : clock_choice
    task automatic locked_write();
        apb(1'b1, LINK_CAP_OFFSET, 32'h0);
        apb(1'b0, LINK_CAP_OFFSET, 32'h0);
        check(rd, 32'h02015c21);
        check({26'h0, trainWidth}, 32'h2);
    endtask : locked_write
    task automatic unlocked_write();
        apb(1'b1, SW_CTRL_OFFSET, 32'h1);
        apb(1'b1, LINK_CAP_OFFSET, 32'hffffffff);
        apb(1'b0, LINK_CAP_OFFSET, 32'h0);
        check(rd, 32'h0207dff1);
        check({26'h0, trainWidth}, 32'h1);
        check(rdDn, 32'h031fdc11);
        apb(1'b1, LINK_CAP_OFFSET, 32'h00000010);
        apb(1'b0, LINK_CAP_OFFSET, 32'h0);
        check(rd, 32'h02005c11);
        check({26'h0, trainWidth}, 32'h1);
        check(rdDn, 32'h03005c11);
        check({26'h0, trainWidthDn}, 32'h1);
    endtask : unlocked_write
    task automatic unmapped();
        apb(1'b0, 12'h200, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h200, 32'h5);
        check({31'h0, err}, 32'h1);
    endtask : unmapped
    task automatic tally_and_finish();
        if (errors == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        reset_values();
        clock_choice();
        locked_write();
        unlocked_write();
        unmapped();
        tally_and_finish();
    end
endmodule : test_switch_port_link_capabilities
